// >>> verilog/srav_regs.svh
// Overview of operation
// - Three request outputs: receive, transmit, modem change.
// - Context opens by acknowledge inputs or by register writes.
// - One acknowledge input per type selects servicing of that type.
// - Acknowledge is a read returning the matching type's vector register.
// - Posting copies seed upper five bits, low three get type code.
// - Codes: 001 modem, 010 transmit, 011 receive, 111 receive exception.
// - Each channel has its own seed; host loads its upper five bits.
// - Any end-of-service write returns device to normal mode.
// - Context start loads requesting channel into channel access register.
// - Access after end-of-service stalls about 1 us via transfer ack.
`ifndef SRAV_REGS_SVH
`define SRAV_REGS_SVH

// ----------------------------------------------------------------
// Register offsets on the 7-bit host address
// ----------------------------------------------------------------
`define SRAV_OFF_MASTER  7'h67
`define SRAV_OFF_CAR     7'h68
`define SRAV_OFF_SEED    7'h18
`define SRAV_OFF_RXVEC   7'h43
`define SRAV_OFF_TXVEC   7'h42
`define SRAV_OFF_MDVEC   7'h41
`define SRAV_OFF_RXCHAN  7'h44
`define SRAV_OFF_TXCHAN  7'h45
`define SRAV_OFF_MDCHAN  7'h46
`define SRAV_OFF_EOS     7'h60
`define SRAV_OFF_RXREQ   7'h6B
`define SRAV_OFF_TXREQ   7'h6A
`define SRAV_OFF_MDREQ   7'h69

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SRAV_SEED_LSB    3
`define SRAV_CODE_W      3
`define SRAV_REQ_FLAG_LSB 6
`define SRAV_REQ_TYPE_LSB 2
`define SRAV_RST_VEC     8'h00
`define SRAV_RST_SEED    5'h00
`define SRAV_RST_CHAN    2'h0

// Request type codes in the low vector bits
`define SRAV_CODE_MODEM  3'h1
`define SRAV_CODE_TX     3'h2
`define SRAV_CODE_RX     3'h3
`define SRAV_CODE_RXEXC  3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SRAV_CLK_MHZ      50
`define SRAV_HOUSEKEEP_NS 1000
`define SRAV_HOUSEKEEP_CYC \
  ((`SRAV_HOUSEKEEP_NS * `SRAV_CLK_MHZ + 999) / 1000)

`endif

// >>> verilog/srav_pkg.sv
package srav_pkg;

  // Kind of host cycle seen on the pins
  typedef enum logic [1:0] {
    SRAV_RD  = 2'h0,
    SRAV_WR  = 2'h1,
    SRAV_ACK = 2'h2
  } srav_kind_type;

  // Host bus cycle sequencer states, Gray along idle-wait-done
  typedef enum logic [1:0] {
    SRAV_IDLE = 2'h0,
    SRAV_WAIT = 2'h1,
    SRAV_DONE = 2'h3
  } srav_state_type;

  // Host pins as sampled
  typedef struct packed {
    logic       cs_n;
    logic       ds_n;
    logic       rw_n;
    logic [2:0] ack_n;   // modem, transmit, receive
    logic       grant_n;
    logic [6:0] addr;
    logic [7:0] wdata;
  } srav_pins_type;

  // One host request handed to the core
  typedef struct packed {
    srav_kind_type kind;
    logic [1:0]    sel;  // Acknowledged type: 0 rx, 1 tx, 2 modem
    logic [6:0]    addr;
    logic [7:0]    wdata;
  } srav_req_type;

  // Requests from the internal processor, held until taken
  typedef struct packed {
    logic [2:0] req;     // modem, transmit, receive
    logic [1:0] rx_chan;
    logic [1:0] tx_chan;
    logic [1:0] md_chan;
    logic       rx_exc;
  } srav_post_type;

  // Receive acknowledge wins over transmit, transmit over modem
  function automatic logic [1:0] srav_ack_sel(input logic [2:0] ack_n);
    if (!ack_n[0]) begin
      return 2'h0;
    end else if (!ack_n[1]) begin
      return 2'h1;
    end else begin
      return 2'h2;
    end
  endfunction

endpackage

// >>> verilog/srav_host_if.sv
`timescale 1ns/1ps
`include "srav_regs.svh"
module srav_host_if import srav_pkg::*; (
  input  wire logic          sys_clk_in,
  input  wire logic          nrst_in,
  input  wire srav_pins_type pins_in,
  input  wire logic          ready_in,
  input  wire logic [7:0]    rdata_in,
  output srav_req_type       req_out,
  output logic               valid_out,
  output logic               transfer_ack_n_out,
  output logic               data_oe_n_out,
  output logic [7:0]         data_out
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  srav_pins_type  pins_meta;
  srav_pins_type  pins_sync;
  srav_state_type state;

  // Address and data are only used once strobes are stable
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pins_meta <= '1;
      pins_sync <= '1;
    end else begin
      pins_meta <= pins_in;
      pins_sync <= pins_meta;
    end
  end

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  wire       strobe   = !pins_sync.ds_n;
  wire       sel_cs   = strobe && !pins_sync.cs_n;
  wire       sel_ack  = strobe && pins_sync.cs_n && !pins_sync.grant_n
                        && (pins_sync.ack_n != 3'h7);
  wire       start    = (state == SRAV_IDLE) && (sel_cs || sel_ack);
  wire       fire     = valid_out && ready_in;
  wire srav_kind_type next_kind = sel_ack ? SRAV_ACK :
                                  (pins_sync.rw_n ? SRAV_RD : SRAV_WR);

  // Capture the request, then hold it until the core accepts
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_out   <= '0;
      valid_out <= 1'b0;
    end else if (start) begin
      req_out   <= '{next_kind, srav_ack_sel(pins_sync.ack_n),
                     pins_sync.addr, pins_sync.wdata};
      valid_out <= 1'b1;
    end else if (fire) begin
      valid_out <= 1'b0;
    end
  end

  // transfer ack only once the core is ready
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state              <= SRAV_IDLE;
      transfer_ack_n_out <= 1'b1;
      data_oe_n_out      <= 1'b1;
      data_out           <= 8'h00;
    end else begin
      case (state)
        SRAV_IDLE: begin
          if (start) begin
            state <= SRAV_WAIT;
          end
        end
        SRAV_WAIT: begin
          if (fire) begin
            state              <= SRAV_DONE;
            transfer_ack_n_out <= 1'b0;
            data_oe_n_out      <= (req_out.kind == SRAV_WR);
            data_out           <= rdata_in;
          end
        end
        SRAV_DONE: begin
          if (!strobe) begin // Host ends the cycle by removing strobes
            state              <= SRAV_IDLE;
            transfer_ack_n_out <= 1'b1;
            data_oe_n_out      <= 1'b1;
          end
        end
        default: begin
          state <= SRAV_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> verilog/srav_top.sv
`timescale 1ns/1ps
`include "srav_regs.svh"
module srav_top import srav_pkg::*; #(
  parameter int NUM_CHAN = 4
) (
  input  wire logic          sys_clk_in,
  input  wire logic          nrst_in,
  input  wire logic          cs_n_in,
  input  wire logic          ds_n_in,
  input  wire logic          rw_n_in,
  input  wire logic [6:0]    addr_in,
  input  wire logic [7:0]    data_in,
  input  wire logic          rx_ack_n_in,
  input  wire logic          tx_ack_n_in,
  input  wire logic          modem_ack_n_in,
  input  wire logic          chain_grant_in_n_in,
  input  wire srav_post_type post_in,
  output logic [7:0]         data_out,
  output logic               data_oe_n_out,
  output logic               transfer_ack_n_out,
  output logic               rx_request_n_out,
  output logic               tx_request_n_out,
  output logic               modem_request_n_out,
  output logic [2:0]         post_taken_out,
  output logic               context_open_out
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (NUM_CHAN < 1 || NUM_CHAN > 4) begin : g_bad_chan
    $error("NUM_CHAN must lie between 1 and 4");
  end

  localparam logic [5:0] HK_CYC = 6'(`SRAV_HOUSEKEEP_CYC);

  // ----------------------------------------------------------------
  // Host bus sequencer
  // ----------------------------------------------------------------
  srav_pins_type pins;
  srav_req_type  req;
  logic          valid;
  logic          ready;
  logic [7:0]    rdata;

  assign pins = '{cs_n_in, ds_n_in, rw_n_in,
                  {modem_ack_n_in, tx_ack_n_in, rx_ack_n_in},
                  chain_grant_in_n_in, addr_in, data_in};

  srav_host_if u_host_if (
    .sys_clk_in         (sys_clk_in),
    .nrst_in            (nrst_in),
    .pins_in            (pins),
    .ready_in           (ready),
    .rdata_in           (rdata),
    .req_out            (req),
    .valid_out          (valid),
    .transfer_ack_n_out (transfer_ack_n_out),
    .data_oe_n_out      (data_oe_n_out),
    .data_out           (data_out)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0] pend;
  logic [7:0] vec  [3];
  logic [1:0] chan [3];
  logic [4:0] seed [NUM_CHAN];
  logic [1:0] channel_access_reg;
  logic       ctx_open;
  logic [1:0] ctx_type;
  logic [5:0] hk_cnt;

  // Out-of-range channel numbers fall back to channel zero
  function automatic logic [4:0] seed_of(input logic [1:0] c,
                                         input logic [4:0] s [NUM_CHAN]);
    if (int'(c) < NUM_CHAN) begin
      return s[c];
    end
    return s[0];
  endfunction

  // Request information register: flags, type index plus one, channel
  function automatic logic [7:0] req_info(input logic p,
                                          input logic [1:0] t,
                                          input logic [1:0] c);
    return {p, p, 1'b0, {1'b0, t} + 3'h1, c};
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire is_wr  = valid && (req.kind == SRAV_WR);
  wire is_ack = valid && (req.kind == SRAV_ACK);
  wire busy   = (hk_cnt != 6'h00);
  wire hit_master = req.addr == `SRAV_OFF_MASTER;
  wire hit_car    = req.addr == `SRAV_OFF_CAR;
  wire hit_seed   = req.addr == `SRAV_OFF_SEED;
  wire hit_eos    = req.addr == `SRAV_OFF_EOS;
  wire [2:0] hit_vec  = {req.addr == `SRAV_OFF_MDVEC,
                         req.addr == `SRAV_OFF_TXVEC,
                         req.addr == `SRAV_OFF_RXVEC};
  wire [2:0] hit_chan = {req.addr == `SRAV_OFF_MDCHAN,
                         req.addr == `SRAV_OFF_TXCHAN,
                         req.addr == `SRAV_OFF_RXCHAN};
  wire [2:0] hit_req  = {req.addr == `SRAV_OFF_MDREQ,
                         req.addr == `SRAV_OFF_TXREQ,
                         req.addr == `SRAV_OFF_RXREQ};

  // hold every access during housekeeping
  // An acknowledge with nothing pending hangs, as a chain end would
  assign ready = !busy && !(is_ack && (ctx_open || !pend[req.sel]));
  wire fire = valid && ready;

  // Software switch: channel access written with flags and a type
  wire [1:0] sw_sel  = 2'(req.wdata[`SRAV_REQ_TYPE_LSB +: 3] - 3'h1);
  wire       sw_flag = req.wdata[`SRAV_REQ_FLAG_LSB +: 2] != 2'h0;
  // context forced by channel access write
  wire sw_go = is_wr && hit_car && sw_flag && (sw_sel != 2'h3)
               && pend[sw_sel] && !ctx_open;
  wire [1:0] start_sel = is_ack ? req.sel : sw_sel;
  wire ctx_start = fire && (is_ack || sw_go);
  wire ctx_end = fire && is_wr && ctx_open && (hit_eos
                 || (hit_req[ctx_type] && !sw_flag));

  // no repost while that type's context is open
  wire [2:0] blocked = ctx_open ? (3'h1 << ctx_type) : 3'h0;
  wire [2:0] post    = post_in.req & ~pend & ~blocked;
  wire [1:0] post_chan [3];
  assign post_chan[0] = post_in.rx_chan;
  assign post_chan[1] = post_in.tx_chan;
  assign post_chan[2] = post_in.md_chan;
  wire [2:0] post_code [3];
  assign post_code[0] = post_in.rx_exc ? `SRAV_CODE_RXEXC : `SRAV_CODE_RX;
  assign post_code[1] = `SRAV_CODE_TX;
  assign post_code[2] = `SRAV_CODE_MODEM;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [1:0] rd_t = hit_vec[0] || hit_chan[0] || hit_req[0] ? 2'h0 :
                    hit_vec[1] || hit_chan[1] || hit_req[1] ? 2'h1 : 2'h2;
  // master request register shows pending types
  assign rdata = is_ack           ? vec[req.sel] :
                 hit_master       ? {5'h00, pend} :
                 (|hit_vec)       ? vec[rd_t] :
                 (|hit_chan)      ? {6'h00, chan[rd_t]} :
                 (|hit_req)       ? req_info(pend[rd_t], rd_t, chan[rd_t]) :
                 hit_car          ? {6'h00, channel_access_reg} :
                 hit_seed         ? {seed_of(channel_access_reg, seed), 3'h0} :
                 8'h00;

  // ----------------------------------------------------------------
  // Requests and vectors per type
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend           <= 3'h0;
      post_taken_out <= 3'h0;
      for (int t = 0; t < 3; t++) begin
        vec[t]  <= `SRAV_RST_VEC;
        chan[t] <= `SRAV_RST_CHAN;
      end
    end else begin
      post_taken_out <= post;
      for (int t = 0; t < 3; t++) begin
        if (post[t]) begin
          // seed upper bits plus type code
          vec[t]  <= {seed_of(post_chan[t], seed), post_code[t]};
          chan[t] <= post_chan[t];
          pend[t] <= 1'b1;
        end else if (ctx_start && start_sel == 2'(t)) begin
          // request held until its context starts
          pend[t] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_request_n_out    <= 1'b1;
      tx_request_n_out    <= 1'b1;
      modem_request_n_out <= 1'b1;
    end else begin
      rx_request_n_out    <= !(pend[0] || post[0]);
      tx_request_n_out    <= !(pend[1] || post[1]);
      modem_request_n_out <= !(pend[2] || post[2]);
    end
  end

  // ----------------------------------------------------------------
  // Context, channel pointer and housekeeping
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctx_open         <= 1'b0;
      ctx_type         <= 2'h0;
      channel_access_reg              <= `SRAV_RST_CHAN;
      hk_cnt           <= 6'h00;
      context_open_out <= 1'b0;
    end else begin
      context_open_out <= ctx_open;
      if (ctx_start) begin
        ctx_open <= 1'b1;
        ctx_type <= start_sel;
        channel_access_reg      <= chan[start_sel];
      end else if (ctx_end) begin
        ctx_open <= 1'b0;
        hk_cnt   <= HK_CYC;
      end else begin
        if (fire && is_wr && hit_car) begin
          channel_access_reg <= req.wdata[1:0];
        end
        if (busy) begin
          hk_cnt <= hk_cnt - 6'h01;
        end
      end
    end
  end

  // host loads seed upper bits of the addressed channel
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        seed[c] <= `SRAV_RST_SEED;
      end
    end else if (fire && is_wr && hit_seed && int'(channel_access_reg) < NUM_CHAN) begin
      seed[channel_access_reg] <= req.wdata[`SRAV_SEED_LSB +: 5];
    end
  end

endmodule

// >>> dv/srav_properties.sv
`timescale 1ns/1ps
`include "srav_regs.svh"
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module srav_properties import srav_pkg::*; #(
  parameter int NUM_CHAN = 4
) (
  input wire logic          sys_clk_in,
  input wire logic          nrst_in,
  input wire logic          cs_n_in,
  input wire logic          ds_n_in,
  input wire logic          rw_n_in,
  input wire logic [6:0]    addr_in,
  input wire logic [7:0]    data_in,
  input wire logic          rx_ack_n_in,
  input wire logic          tx_ack_n_in,
  input wire logic          modem_ack_n_in,
  input wire logic          chain_grant_in_n_in,
  input wire srav_post_type post_in,
  input wire logic [7:0]    data_out,
  input wire logic          data_oe_n_out,
  input wire logic          transfer_ack_n_out,
  input wire logic          rx_request_n_out,
  input wire logic          tx_request_n_out,
  input wire logic          modem_request_n_out,
  input wire logic [2:0]    post_taken_out,
  input wire logic          context_open_out
);
  // One clock domain; reset silences every check
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  // A post is only taken from a live request with nothing pending
  property p_post(logic tk, logic rq, logic pr);
    tk |-> !rq && $past(pr) && $past(rq);
  endproperty

  a_post_rx_taken: assert property (p_post(post_taken_out[0],
    rx_request_n_out, post_in.req[0])) else $error("rx post taken badly");
  a_post_tx_taken: assert property (p_post(post_taken_out[1],
    tx_request_n_out, post_in.req[1])) else $error("tx post taken badly");
  a_post_md_taken: assert property (p_post(post_taken_out[2],
    modem_request_n_out, post_in.req[2])) else $error("modem post bad");
  a_request_held: assert property (($rose(rx_request_n_out) ||
    $rose(tx_request_n_out) || $rose(modem_request_n_out))
    |-> ##[0:2] context_open_out) else $error("request dropped early");
  a_ack_opens_ctx: assert property ((!rx_ack_n_in || !tx_ack_n_in ||
    !modem_ack_n_in) && !chain_grant_in_n_in && $fell(transfer_ack_n_out)
    |-> ##[0:2] context_open_out) else $error("ack left context shut");
  a_eos_closes: assert property (!cs_n_in && !ds_n_in &&
    !rw_n_in && addr_in == `SRAV_OFF_EOS && $fell(transfer_ack_n_out)
    |-> ##[0:60] !context_open_out) else $error("context not closed");
  a_drive_on_read: assert property (!data_oe_n_out
    |-> !transfer_ack_n_out && rw_n_in) else $error("bus driven oddly");
  a_ack_after_strobe: assert property ($fell(transfer_ack_n_out)
    |-> !$past(ds_n_in, 3)) else $error("ack without strobe");
  a_ack_until_off: assert property ($rose(transfer_ack_n_out)
    |-> $past(ds_n_in) && $past(ds_n_in, 2)) else $error("ack cut short");

  // Main scenarios reached
  c_post_rx:   cover property (post_taken_out[0]);
  c_ctx_close: cover property ($fell(context_open_out));
  c_bus_drive: cover property (!data_oe_n_out);
endmodule

bind srav_top srav_properties #(.NUM_CHAN(NUM_CHAN)) u_props (
  .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n_in),
  .ds_n_in(ds_n_in), .rw_n_in(rw_n_in), .addr_in(addr_in),
  .data_in(data_in), .rx_ack_n_in(rx_ack_n_in),
  .tx_ack_n_in(tx_ack_n_in), .modem_ack_n_in(modem_ack_n_in),
  .chain_grant_in_n_in(chain_grant_in_n_in), .post_in(post_in),
  .data_out(data_out), .data_oe_n_out(data_oe_n_out),
  .transfer_ack_n_out(transfer_ack_n_out),
  .rx_request_n_out(rx_request_n_out),
  .tx_request_n_out(tx_request_n_out),
  .modem_request_n_out(modem_request_n_out),
  .post_taken_out(post_taken_out), .context_open_out(context_open_out));

// >>> dv/srav_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host CPU bus master with acknowledge decode
// ----------------------------------------------------------------
module srav_host_model import srav_pkg::*; (
  input  wire logic       sys_clk_in,
  input  wire logic       transfer_ack_n_in,
  input  wire logic       data_oe_n_in,
  input  wire logic [7:0] rdata_in,
  output logic            cs_n_out,
  output logic            ds_n_out,
  output logic            rw_n_out,
  output logic [6:0]      addr_out,
  output logic [7:0]      wdata_out,
  output logic [2:0]      ack_n_out,
  output logic            grant_n_out
);
  // Idle host pins
  // Acknowledge and grant rest high so no stray acknowledge starts
  initial begin
    {cs_n_out, ds_n_out, rw_n_out, grant_n_out} = 4'hF;
    ack_n_out = 3'h7;
    addr_out  = 7'h00;
    wdata_out = 8'h00;
  end

  // One whole cycle; pins move only on falling edges
  task automatic xfer(input srav_kind_type k, input logic [1:0] sel,
                      input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] rd, output int cyc);
    int n;
    @(negedge sys_clk_in);
    addr_out  = a;
    wdata_out = wd;
    rw_n_out  = (k != SRAV_WR);
    cs_n_out    = (k == SRAV_ACK);
    grant_n_out = (k != SRAV_ACK);
    ack_n_out   = (k == SRAV_ACK) ? ~(3'h1 << sel) : 3'h7;
    ds_n_out = 1'b0;
    cyc = 0;
    do begin
      @(posedge sys_clk_in);
      cyc++;
    end while (transfer_ack_n_in !== 1'b0 && cyc < 400);
    // An undriven bus reads back garbled, never as a stale value
    rd = (data_oe_n_in === 1'b0) ? rdata_in : ~rdata_in;
    @(negedge sys_clk_in);
    {cs_n_out, ds_n_out, grant_n_out} = 3'h7;
    ack_n_out = 3'h7;
    wdata_out = ~wdata_out;
    // Wait for the release so cycles never overlap
    n = 0;
    while (transfer_ack_n_in !== 1'b1 && n < 400) begin
      @(negedge sys_clk_in);
      n++;
    end
  endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "srav_regs.svh"
module tb_top import srav_pkg::*; ();
  logic          sys_clk_in = 1'b0;
  logic          nrst_in    = 1'b0;
  srav_post_type pst;
  logic          cs_n, ds_n, rw_n, grant_n, oe_n, tack_n, ctx;
  logic [6:0]    addr;
  logic [7:0]    wdata, dout;
  logic [2:0]    ack_n, req_n, taken;
  int            n_mismatch  = 0;
  int            check_count = 0;
  int            cycles      = 0;
  // Type, channel, seed and code of each acknowledge case
  localparam logic [1:0] TY [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  localparam logic [1:0] CH [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  localparam logic [4:0] SD [4] = '{5'h15, 5'h0A, 5'h1F, 5'h01};
  localparam logic [2:0] CD [4] = '{3'h3, 3'h2, 3'h1, 3'h7};

  always #10 sys_clk_in = ~sys_clk_in;

  srav_top #(.NUM_CHAN(4)) dut (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n),
    .ds_n_in(ds_n), .rw_n_in(rw_n), .addr_in(addr), .data_in(wdata),
    .rx_ack_n_in(ack_n[0]), .tx_ack_n_in(ack_n[1]),
    .modem_ack_n_in(ack_n[2]), .chain_grant_in_n_in(grant_n),
    .post_in(pst), .data_out(dout), .data_oe_n_out(oe_n),
    .transfer_ack_n_out(tack_n), .rx_request_n_out(req_n[0]),
    .tx_request_n_out(req_n[1]), .modem_request_n_out(req_n[2]),
    .post_taken_out(taken), .context_open_out(ctx));

  srav_host_model u_host (
    .sys_clk_in(sys_clk_in), .transfer_ack_n_in(tack_n),
    .data_oe_n_in(oe_n), .rdata_in(dout), .cs_n_out(cs_n),
    .ds_n_out(ds_n), .rw_n_out(rw_n), .addr_out(addr),
    .wdata_out(wdata), .ack_n_out(ack_n), .grant_n_out(grant_n));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string w, input logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", w, e, g);
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    int         c;
    u_host.xfer(SRAV_WR, 2'h0, a, d, x, c);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] e, string w);
    logic [7:0] x;
    int         c;
    u_host.xfer(SRAV_RD, 2'h0, a, 8'h00, x, c);
    check(w, e, x);
  endtask

  // Raise a post and wait, bounded, for it to be taken
  task automatic post_req(input logic [1:0] t, logic [1:0] ch, logic exc);
    int n;
    @(negedge sys_clk_in);
    pst.req[t] = 1'b1;
    {pst.rx_chan, pst.tx_chan, pst.md_chan, pst.rx_exc} = {ch, ch, ch, exc};
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (taken[t] !== 1'b1 && n < 8);
    pst.req[t] = 1'b0;
    check("post taken", 8'h01, {7'h00, taken[t]});
    check("request low", 8'h00, {7'h00, req_n[t]});
  endtask

  task automatic t_idle();
    check("idle outputs", 8'hF8,
          {req_n, oe_n, tack_n, ctx, taken[1:0]});
    rdc(`SRAV_OFF_MASTER, 8'h00, "master idle");
    rdc(7'h7F, 8'h00, "unmapped read");
  endtask

  // Acknowledge pins, every type code, then end of service
  task automatic t_hw_ack();
    logic [7:0] v;
    int         c;
    for (int i = 0; i < 4; i++) begin
      wr(`SRAV_OFF_CAR, {6'h00, CH[i]});
      wr(`SRAV_OFF_SEED, {SD[i], 3'h5});
      rdc(`SRAV_OFF_SEED, {SD[i], 3'h0}, "seed");
      post_req(TY[i], CH[i], i == 3);
      rdc(`SRAV_OFF_MASTER, 8'h01 << TY[i], "master");
      u_host.xfer(SRAV_ACK, TY[i], 7'h00, 8'h00, v, c);
      check("ack vector", {SD[i], CD[i]}, v);
      check("type code", {5'h00, CD[i]}, {5'h00, v[2:0]});
      check("request cleared", 8'h01, {7'h00, req_n[TY[i]]});
      check("context open", 8'h01, {7'h00, ctx});
      rdc(`SRAV_OFF_CAR, {6'h00, CH[i]}, "channel access");
      rdc(7'(`SRAV_OFF_RXCHAN + TY[i]), {6'h00, CH[i]}, "channel");
      rdc(7'(`SRAV_OFF_RXVEC - TY[i]), {SD[i], CD[i]}, "vector");
      // A second post of the open type must wait
      @(negedge sys_clk_in);
      pst.req[TY[i]] = 1'b1;
      repeat (4) @(negedge sys_clk_in);
      check("no repost", 8'h01, {7'h00, req_n[TY[i]]});
      pst.req[TY[i]] = 1'b0;
      wr(`SRAV_OFF_EOS, 8'h5A);
      u_host.xfer(SRAV_RD, 2'h0, `SRAV_OFF_MASTER, 8'h00, v, c);
      check("stall", 8'h01, {7'h00, c >= 40});
      check("context closed", 8'h00, {7'h00, ctx});
    end
  endtask

  // Context opened and closed by register writes alone
  task automatic t_soft();
    post_req(2'h1, 2'h2, 1'b0);
    rdc(`SRAV_OFF_TXREQ, 8'hCA, "request info");
    wr(`SRAV_OFF_CAR, 8'hCA);
    check("soft open", 8'h01, {7'h00, ctx});
    check("soft release", 8'h01, {7'h00, req_n[1]});
    wr(`SRAV_OFF_TXREQ, 8'h0A);
    rdc(`SRAV_OFF_MASTER, 8'h00, "master after");
    check("soft close", 8'h00, {7'h00, ctx});
  endtask

  // Hang guard: far above the several hundred cycles the run needs
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    pst = '0;
    repeat (2) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    t_idle();
    t_hw_ack();
    t_soft();
    stop_test();
  end
endmodule
